// *** urbs_pkg.sv ***
// Shared constants for the serial receive buffer and status block.
`default_nettype none
package urbs_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_DATA   = 5'h00;
    localparam logic [4:0] ADDR_STAT_A = 5'h04;
    localparam logic [4:0] ADDR_CTRL_B = 5'h08;
    localparam logic [4:0] ADDR_CTRL_C = 5'h0C;
    localparam logic [4:0] ADDR_BAUD   = 5'h10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STA_RXC   = 7;
    localparam int STA_FE    = 4;
    localparam int STA_DOR   = 3;
    localparam int STA_PE    = 2;
    localparam int CTB_RXCIE = 7;
    localparam int CTB_RXEN  = 4;
    localparam int CTB_CS2   = 2;
    localparam int CTB_RXB8  = 1;
    localparam int CTC_PEN   = 5;
    localparam int CTC_PODD  = 4;
    localparam int CTC_STOP  = 3;
    localparam int CTC_CS_LO = 1;
    localparam int ENT_PE    = 9;
    localparam int ENT_DOR   = 10;
    localparam int ENT_FE    = 11;
    localparam int ENT_W     = 12;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [2:0]  CS_RST   = 3'h3;
    localparam logic [2:0]  CS_NINE  = 3'h7;
    localparam logic [15:0] BAUD_RST = 16'h000A;
    localparam logic [3:0]  OVS_MID  = 4'h7;
    localparam logic [3:0]  OVS_LAST = 4'hF;
    localparam logic [3:0]  BITS_MIN = 4'h5;
    localparam logic [3:0]  BITS_MAX = 4'h8;
    localparam logic [3:0]  BITS_NINE = 4'h9;

    // Number of data bits for a character size code.
    function automatic logic [3:0] urbs_data_bits(input logic [2:0] cs);
        if (cs == CS_NINE) begin
            return BITS_NINE;
        end else if (cs[2]) begin
            return BITS_MAX;
        end
        return BITS_MIN + {2'h0, cs[1:0]};
    endfunction
endpackage
`default_nettype wire

// *** urbs_baud_div.sv ***
// Divider that makes the sixteen-times oversampling enable pulse.
`default_nettype none
module urbs_baud_div #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         enable_i,
    input  wire logic [W-1:0] divisor_i,
    output logic              tick_o
);
    generate
        if (W < 4) begin : g_chk
            $error("urbs_baud_div: W must be at least 4");
        end
    endgenerate

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;

    always_comb begin
        next_cnt  = cnt + 1'b1;
        next_tick = 1'b0;
        if (!enable_i) begin
            next_cnt = '0;
        end else if (cnt >= divisor_i) begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule
`default_nettype wire

// *** urbs_rx_frame.sv ***
// Receive shift logic that turns the serial line into framed characters.
`default_nettype none
module urbs_rx_frame
    import urbs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic       tick_i,
    input  wire logic       rxd_i,
    input  wire logic [2:0] char_size_i,
    input  wire logic       parity_enable_i,
    input  wire logic       parity_odd_i,
    output logic            start_o,
    output logic            done_o,
    output logic [8:0]      data_o,
    output logic            frame_error_o,
    output logic            parity_error_o
);
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_DATA, S_PARITY, S_STOP
    } urbs_rx_state_e;

    urbs_rx_state_e state;
    urbs_rx_state_e next_state;
    logic [3:0] os_cnt, next_os;
    logic [3:0] bit_idx, next_bit;
    logic [8:0] shreg, next_sh;
    logic       par_bit, next_par;
    logic       pen, next_pen;
    logic       next_start, next_done, next_fe, next_pe;
    logic [8:0] next_data;
    logic       sample;
    logic       rxd_q;

    assign sample = tick_i && (os_cnt == OVS_LAST);

    always_comb begin
        next_state = state;
        next_os    = tick_i ? os_cnt + 4'h1 : os_cnt;
        next_bit   = bit_idx;
        next_sh    = shreg;
        next_par   = par_bit;
        next_pen   = pen;
        next_start = 1'b0;
        next_done  = 1'b0;
        next_fe    = frame_error_o;
        next_pe    = parity_error_o;
        next_data  = data_o;
        case (state)
            S_IDLE: begin
                next_os = 4'h0;
                if (rxd_q && !rxd_i) begin
                    next_state = S_START;
                end
            end
            S_START: begin
                if (tick_i && os_cnt == OVS_MID) begin
                    if (rxd_i) begin
                        next_state = S_IDLE;
                    end else begin
                        next_state = S_DATA;
                        next_os    = 4'h0;
                        next_bit   = 4'h0;
                        next_sh    = '0;
                        next_pen   = parity_enable_i;
                        next_start = 1'b1;
                    end
                end
            end
            S_DATA: begin
                if (sample) begin
                    next_sh[bit_idx] = rxd_i;
                    next_bit = bit_idx + 4'h1;
                    if (bit_idx == urbs_data_bits(char_size_i) - 4'h1) begin
                        next_state = pen ? S_PARITY : S_STOP;
                    end
                end
            end
            S_PARITY: begin
                if (sample) begin
                    next_par   = rxd_i;
                    next_state = S_STOP;
                end
            end
            S_STOP: begin
                if (sample) begin
                    next_done  = 1'b1;
                    next_fe    = !rxd_i;
                    next_pe    = pen & (^shreg ^ par_bit ^ parity_odd_i);
                    next_data  = shreg;
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (!enable_i) begin
            next_state = S_IDLE;
            next_start = 1'b0;
            next_done  = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state          <= S_IDLE;
            rxd_q          <= 1'b1;
            os_cnt         <= 4'h0;
            bit_idx        <= 4'h0;
            shreg          <= '0;
            par_bit        <= 1'b0;
            pen            <= 1'b0;
            start_o        <= 1'b0;
            done_o         <= 1'b0;
            data_o         <= '0;
            frame_error_o  <= 1'b0;
            parity_error_o <= 1'b0;
        end else begin
            state          <= next_state;
            rxd_q          <= rxd_i;
            os_cnt         <= next_os;
            bit_idx        <= next_bit;
            shreg          <= next_sh;
            par_bit        <= next_par;
            pen            <= next_pen;
            start_o        <= next_start;
            done_o         <= next_done;
            data_o         <= next_data;
            frame_error_o  <= next_fe;
            parity_error_o <= next_pe;
        end
    end
endmodule
`default_nettype wire

// *** urbs_top.sv ***
// Serial receive buffer, status flags and Wishbone register slave.
`default_nettype none
module urbs_top
    import urbs_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        gie_i,
    input  wire logic        serial_in_pin_i,
    output logic             rx_pin_override_o,
    output logic             rx_irq_o
);
    generate
        if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("urbs_top: DEPTH must be a power of two from 2 to 8");
        end
    endgenerate

    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Pin synchroniser and receiver
    // ------------------------------------------------------------
    logic        pin_s1, pin_s2;
    logic        rx_complete_irq_enable, receiver_enable;
    logic [2:0]  char_size_select;
    logic        parity_enable_bit, parity_odd_select, stop_bit_count_select;
    logic [15:0] baud_div;
    logic        tick, rx_start, rx_done, rx_fe, rx_pe;
    logic [8:0]  rx_data;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= serial_in_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    urbs_baud_div #(.W(16)) u_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .enable_i  (receiver_enable),
        .divisor_i (baud_div),
        .tick_o    (tick)
    );

    urbs_rx_frame u_rx (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .enable_i        (receiver_enable),
        .tick_i          (tick),
        .rxd_i           (pin_s2),
        .char_size_i     (char_size_select),
        .parity_enable_i (parity_enable_bit),
        .parity_odd_i    (parity_odd_select),
        .start_o         (rx_start),
        .done_o          (rx_done),
        .data_o          (rx_data),
        .frame_error_o   (rx_fe),
        .parity_error_o  (rx_pe)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req, wr, rd, pop, push, full, rxc, ovr_evt;
    logic [ENT_W-1:0] mem [DEPTH];
    logic [ENT_W-1:0] head;
    logic [PW-1:0]    wptr, rptr;
    logic [PW:0]      count;

    assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr   = req & wb_we_i;
    assign rd   = req & ~wb_we_i;
    assign head = mem[rptr];
    assign rxc  = count != '0;
    assign full = count == (PW + 1)'(DEPTH);
    assign pop  = rd && (wb_adr_i == ADDR_DATA) && rxc;

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    logic             pend, next_pend, dor_pend, next_dor_pend;
    logic [ENT_W-1:0] pend_ent, next_pend_ent;
    logic [ENT_W-1:0] next_mem [DEPTH];
    logic [PW-1:0]    next_wptr, next_rptr;
    logic [PW:0]      next_count;

    assign push    = receiver_enable & pend & (~full | pop);
    assign ovr_evt = receiver_enable & rx_start & pend & full & ~pop;

    always_comb begin
        next_mem      = mem;
        next_wptr     = wptr;
        next_rptr     = rptr;
        next_count    = count;
        next_pend     = pend;
        next_pend_ent = pend_ent;
        next_dor_pend = dor_pend;
        if (!receiver_enable) begin
            next_wptr     = '0;
            next_rptr     = '0;
            next_count    = '0;
            next_pend     = 1'b0;
            next_dor_pend = 1'b0;
        end else begin
            if (push) begin
                next_mem[wptr] = pend_ent;
                next_mem[wptr][ENT_DOR] = dor_pend;
                next_wptr     = wptr + 1'b1;
                next_pend     = 1'b0;
                next_dor_pend = 1'b0;
            end
            if (ovr_evt) begin
                next_pend     = 1'b0;
                next_dor_pend = 1'b1;
            end
            if (pop) begin
                next_rptr = rptr + 1'b1;
            end
            next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
            if (rx_done) begin
                next_pend = 1'b1;
                next_pend_ent = {rx_fe, 1'b0, rx_pe, rx_data};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wptr     <= '0;
            rptr     <= '0;
            count    <= '0;
            pend     <= 1'b0;
            pend_ent <= '0;
            dor_pend <= 1'b0;
        end else begin
            mem      <= next_mem;
            wptr     <= next_wptr;
            rptr     <= next_rptr;
            count    <= next_count;
            pend     <= next_pend;
            pend_ent <= next_pend_ent;
            dor_pend <= next_dor_pend;
        end
    end

    // ------------------------------------------------------------
    // Control registers, read data and outputs
    // ------------------------------------------------------------
    logic        next_ie, next_en, next_pen, next_podd, next_stop;
    logic [2:0]  next_cs;
    logic [15:0] next_baud;
    logic [31:0] next_dat;
    logic        next_ack, next_irq;

    always_comb begin
        next_ie   = rx_complete_irq_enable;
        next_en   = receiver_enable;
        next_cs   = char_size_select;
        next_pen  = parity_enable_bit;
        next_podd = parity_odd_select;
        next_stop = stop_bit_count_select;
        next_baud = baud_div;
        next_dat  = '0;
        next_ack  = req;
        if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_CTRL_B: begin
                    next_ie    = wb_dat_i[CTB_RXCIE];
                    next_en    = wb_dat_i[CTB_RXEN];
                    next_cs[2] = wb_dat_i[CTB_CS2];
                end
                ADDR_CTRL_C: begin
                    next_pen     = wb_dat_i[CTC_PEN];
                    next_podd    = wb_dat_i[CTC_PODD];
                    next_stop    = wb_dat_i[CTC_STOP];
                    next_cs[1:0] = wb_dat_i[CTC_CS_LO +: 2];
                end
                ADDR_BAUD: begin
                    next_baud[7:0] = wb_dat_i[7:0];
                end
                default: begin
                    next_baud = baud_div;
                end
            endcase
        end
        if (wr && wb_sel_i[1] && wb_adr_i == ADDR_BAUD) begin
            next_baud[15:8] = wb_dat_i[15:8];
        end
        if (rd) begin
            case (wb_adr_i)
                ADDR_DATA: begin
                    next_dat[7:0] = rxc ? head[7:0] : 8'h00;
                end
                ADDR_STAT_A: begin
                    next_dat[STA_RXC] = rxc;
                    next_dat[STA_FE]  = rxc & head[ENT_FE];
                    next_dat[STA_DOR] = rxc & head[ENT_DOR];
                    next_dat[STA_PE]  = rxc & head[ENT_PE]
                                        & parity_enable_bit;
                end
                ADDR_CTRL_B: begin
                    next_dat[CTB_RXCIE] = rx_complete_irq_enable;
                    next_dat[CTB_RXEN]  = receiver_enable;
                    next_dat[CTB_CS2]   = char_size_select[2];
                    next_dat[CTB_RXB8]  = rxc & head[8];
                end
                ADDR_CTRL_C: begin
                    next_dat[CTC_PEN]  = parity_enable_bit;
                    next_dat[CTC_PODD] = parity_odd_select;
                    next_dat[CTC_STOP] = stop_bit_count_select;
                    next_dat[CTC_CS_LO +: 2] = char_size_select[1:0];
                end
                ADDR_BAUD: begin
                    next_dat[15:0] = baud_div;
                end
                default: begin
                    next_dat = '0;
                end
            endcase
        end
        next_irq = rxc & rx_complete_irq_enable & gie_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_complete_irq_enable <= 1'b0;
            receiver_enable        <= 1'b0;
            char_size_select       <= CS_RST;
            parity_enable_bit      <= 1'b0;
            parity_odd_select      <= 1'b0;
            stop_bit_count_select  <= 1'b0;
            baud_div               <= BAUD_RST;
            wb_dat_o               <= '0;
            wb_ack_o               <= 1'b0;
            rx_irq_o               <= 1'b0;
            rx_pin_override_o      <= 1'b0;
        end else begin
            rx_complete_irq_enable <= next_ie;
            receiver_enable        <= next_en;
            char_size_select       <= next_cs;
            parity_enable_bit      <= next_pen;
            parity_odd_select      <= next_podd;
            stop_bit_count_select  <= next_stop;
            baud_div               <= next_baud;
            wb_dat_o               <= next_dat;
            wb_ack_o               <= next_ack;
            rx_irq_o               <= next_irq;
            rx_pin_override_o      <= next_en;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_stat_rd;
        rd && wb_adr_i == ADDR_STAT_A;
    endsequence
    sequence s_ack_after;
        wb_ack_o;
    endsequence

    AST_RXC_READ: assert property (s_stat_rd ##1 s_ack_after |->
        wb_dat_o[STA_RXC] == $past(count != '0))
        else $error("receive complete read does not match buffer fill");
    AST_ADVANCE: assert property (pop && !push |=>
        count == $past(count) - 1'b1)
        else $error("data read did not advance the buffer");
    AST_FLUSH: assert property (!receiver_enable |=>
        count == '0 ##1 !rx_irq_o)
        else $error("disabled receiver left frames buffered");
    AST_IRQ: assert property (rx_irq_o == $past(rxc
        && rx_complete_irq_enable && gie_i))
        else $error("interrupt request does not follow receive complete");
    AST_NO_ERR_IRQ: assert property (count == '0 |=> !rx_irq_o)
        else $error("interrupt raised with an empty buffer");
    AST_ERR_WR: assert property (wr && wb_adr_i == ADDR_STAT_A && !push
        |=> head == $past(head) && count == $past(count))
        else $error("status write altered a buffered error flag");
    AST_OVR: assert property (ovr_evt |=> dor_pend && !pend)
        else $error("overrun not flagged");
    AST_OVR_CLR: assert property (push && !ovr_evt |=> !dor_pend)
        else $error("overrun not cleared on transfer");
    AST_PE_OFF: assert property (s_stat_rd ##0 !parity_enable_bit
        |=> !wb_dat_o[STA_PE])
        else $error("parity error read while checking disabled");
    AST_ABORT: assert property (!receiver_enable |->
        !rx_pin_override_o ##1 !rx_done)
        else $error("disabled receiver still completed a frame");
endmodule
`default_nettype wire

// *** urbs_tx_model.sv ***
// Remote serial transmitter model that drives the receive line.
`default_nettype none
module urbs_tx_model #(
    parameter int BIT_CYC = 32
) (
    input  wire logic clk_i,
    output var logic  line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Line driver
    // ------------------------------------------------------------
    initial line_o = 1'b1;
    // Holds one bit level on the line for a full bit time.
    task automatic put(input logic b);
        line_o <= b;
        repeat (BIT_CYC) @(posedge clk_i);
    endtask
    // Sends start, data LSB first, optional parity, stop, then idle.
    task automatic send(input logic [8:0] d, input int nb, input logic pen,
                        input logic par, input logic stop_v);
        put(1'b0);
        for (int i = 0; i < nb; i++) begin
            put(d[i]);
        end
        if (pen) begin
            put(par);
        end
        put(stop_v);
        put(1'b1);
    endtask
endmodule
`default_nettype wire

// *** uart_receive_buffer_status_bench.sv ***
// Self-checking bench for the serial receive buffer and status block.
`default_nettype none
module uart_receive_buffer_status_bench
    import urbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        gie = 1'b1, ovr, irq, rxd, wb_ack_o;
    logic [4:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, wb_dat_o;
    logic [11:0] q[$];
    int          error_cnt = 0, checked = 0, cycles = 0;
    // ------------------------------------------------------------
    // Design, far side and clock
    // ------------------------------------------------------------
    urbs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .gie_i(gie), .serial_in_pin_i(rxd), .rx_pin_override_o(ovr),
        .rx_irq_o(irq));
    urbs_tx_model #(.BIT_CYC(32)) tx_u (.clk_i(clk_i), .line_o(rxd));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input int d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
    endtask
    task automatic cfg(input logic [2:0] cs, input logic pen, odd, en, stp);
        wb(1'b1, ADDR_CTRL_C, 32'({pen, odd, stp, cs[1:0], 1'b0}));
        wb(1'b1, ADDR_CTRL_B, 32'({1'b1, 2'b0, en, 1'b0, cs[2], 2'b0}));
    endtask
    // Sends a frame and, when push is set, queues the entry that the buffer should hold.
    task automatic frame(input int nb, input logic pen, odd, bpar, bstop,
                         input logic push);
        logic [8:0] d;
        logic       par;
        d = 9'($urandom) & 9'((1 << nb) - 1);
        par = ^d ^ odd ^ bpar;
        tx_u.send(d, nb, pen, par, ~bstop);
        if (push) begin
            q.push_back({bstop, 1'b0, pen & bpar, d});
        end
    endtask
    task automatic pop();
        logic [11:0] e;
        e = q.pop_front();
        wb(1'b0, ADDR_STAT_A, 0);
        chk("status", rdat & 32'h9C, 32'({1'b1, 2'b0, e[11:9], 2'b0}));
        wb(1'b0, ADDR_CTRL_B, 0);
        chk("ninth", 32'(rdat[CTB_RXB8]), 32'(e[8]));
        wb(1'b0, ADDR_DATA, 0);
        chk("data", rdat, 32'(e[7:0]));
    endtask
    task automatic empty();
        wb(1'b0, ADDR_STAT_A, 0);
        chk("rxc", rdat & 32'h80, 0);
        repeat (2) @(posedge clk_i);
        chk("irq off", 32'(irq), 0);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(63));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        empty();
        wb(1'b1, ADDR_BAUD, 1);
        for (int o = 0; o < 2; o++) begin
            cfg(3'h3, 1'b1, 1'(o), 1'b1, 1'b0);
            chk("pin", 32'(ovr), 1);
            frame(8, 1'b1, 1'(o), 1'b0, 1'b0, 1'b1);
            chk("irq", 32'(irq), 1);
            gie <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk("irq gie", 32'(irq), 0);
            gie <= 1'b1;
            pop();
            empty();
        end
        cfg(3'h3, 1'b1, 1'b0, 1'b1, 1'b1);
        frame(8, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        wb(1'b1, ADDR_STAT_A, 32'h63);
        pop();
        cfg(3'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            frame(8, 1'b0, 1'b0, 1'b0, 1'b0, 1'(k != 2));
        end
        q[2][10] = 1'b1;
        repeat (3) pop();
        empty();
        cfg(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        frame(5, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        pop();
        cfg(3'h7, 1'b0, 1'b0, 1'b1, 1'b0);
        frame(9, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        pop();
        frame(9, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        cfg(3'h7, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("pin off", 32'(ovr), 0);
        cfg(3'h7, 1'b0, 1'b0, 1'b1, 1'b0);
        empty();
        test_done();
    end
endmodule
`default_nettype wire
